// >>> rc_core.sv
`timescale 1ns/1ps
`include "rc_params.svh"

module rc_core (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Instruction fetch, combinational read
  output logic [31:0] fetchAddr,
  input wire logic [15:0] fetchData,
  // Data memory
  output logic dReq,
  output logic dWe,
  output logic [31:0] dAddr,
  output logic [31:0] dWdata,
  output rc_pkg::rc_size_t dSize,
  input wire logic [31:0] dRdata,
  input wire logic dAck,
  // Status
  output logic [31:0] cpuFlagsWord,
  output logic slotActive,
  output logic retire
);
  import rc_pkg::*;

  localparam logic [3:0] STATE_LAST = 4'(`RC_STATE_CYC - 1);

  logic [31:0] regs_r [16];
  logic [31:0] pc_r;
  logic [31:0] tgt_r;
  logic [31:0] mach_r;
  logic [31:0] macl_r;
  logic [31:0] flags_r;
  logic slotPend_r;
  rc_state_t st_r;
  logic [3:0] divCnt_r;
  logic stateEn_r;
  logic [1:0] mulCnt_r;
  logic [31:0] mulA_r;
  logic [31:0] mulB_r;
  logic [3:0] mulFn_r;
  logic dReq_r;
  logic dWe_r;
  logic [31:0] dAddr_r;
  logic [31:0] dWdata_r;
  rc_size_t dSize_r;
  logic rmw_r;
  logic [3:0] ldIdx_r;
  logic [7:0] rmwImm_r;
  logic retire_r;

  // Fixed fields of the code word
  wire [15:0] ir = fetchData;
  wire [3:0] op = ir[15:12];
  wire [3:0] rn = ir[11:8];
  wire [3:0] rm = ir[7:4];
  wire [3:0] fn = ir[3:0];
  wire [7:0] imm8 = ir[7:0];

  wire [31:0] vn = regs_r[rn];
  wire [31:0] vm = regs_r[rm];
  wire [31:0] r0 = regs_r[0];

  wire [31:0] sImm = {{24{imm8[7]}}, imm8};
  wire [31:0] zImm = {24'h000000, imm8};

  wire [31:0] pc4 = pc_r + 32'h00000004;
  wire [31:0] seqPc = slotPend_r ? tgt_r : pc_r + 32'h00000002;
  // Literal pool addresses, displacement scaled by size
  wire [31:0] litW = pc4 + {23'h000000, imm8, 1'b0};
  wire [31:0] litL = {pc4[31:2], 2'h0}
                   + {22'h000000, imm8, 2'h0};
  wire [31:0] braTgt = pc4 + {{19{ir[11]}}, ir[11:0], 1'b0};
  wire [31:0] bcTgt = pc4 + {{23{imm8[7]}}, imm8, 1'b0};

  wire tFlag = flags_r[`RC_T_BIT];
  wire run = (st_r == ST_RUN) && stateEn_r;

  wire isAlu = (op == `RC_OP_ALU);
  wire isLitW = (op == `RC_OP_LITW);
  wire isLitL = (op == `RC_OP_LITL);
  wire isLdSt = (op == `RC_OP_LDST);
  wire isAndM = (op == `RC_OP_ANDM);
  wire isJmp = isAlu && (fn == `RC_FN_JMP);
  wire isMul = isAlu && (fn >= `RC_FN_MULW) && (fn <= `RC_FN_MACL);
  wire aluWr = isAlu && !fn[3];

  wire isCmpGe = isAlu && (fn == `RC_FN_CMPGE);
  wire isCmpEq = isAlu && (fn == `RC_FN_CMPEQ);
  wire isCmpEqI = (op == `RC_OP_CMPEQI);
  // Flag writers kept to the compares alone
  wire isCmp = isCmpGe || isCmpEq || isCmpEqI;
  wire cmpVal = isCmpEqI ? (vn == sImm)
              : isCmpGe ? ($signed(vn) >= $signed(vm))
              : (vn == vm);

  // Branch in a slot is not supported and acts as a no-op
  wire isDel = ((op == `RC_OP_BRA) || isJmp) && !slotPend_r;
  wire bcTake = !slotPend_r
              && (((op == `RC_OP_BT) && tFlag)
              || ((op == `RC_OP_BF) && !tFlag));
  wire [31:0] runPc = bcTake ? bcTgt : seqPc;

  wire [31:0] aluRes =
      (fn == `RC_FN_ADD) ? vn + vm
    : (fn == `RC_FN_SUB) ? vn - vm
    : (fn == `RC_FN_AND) ? vn & vm
    : (fn == `RC_FN_OR) ? vn | vm
    : (fn == `RC_FN_XOR) ? vn ^ vm
    : (fn == `RC_FN_MOV) ? vm
    : (fn == `RC_FN_STSL) ? macl_r
    : mach_r;

  wire runWr = run && ((op == `RC_OP_MOVI) || (op == `RC_OP_ADDI)
             || (op == `RC_OP_ANDI) || aluWr);
  wire [31:0] runData =
      (op == `RC_OP_MOVI) ? sImm
    : (op == `RC_OP_ADDI) ? vn + sImm
    : (op == `RC_OP_ANDI) ? vn & zImm
    : aluRes;

  // Memory reached only by loads, stores and the memory AND
  wire memStart = run && (isLitW || isLitL || isLdSt || isAndM);
  // bit0 store, bit1 indexed with R0
  wire [31:0] lsBase = ir[0] ? vn : vm;
  wire [31:0] lsAddr = lsBase + (ir[1] ? r0 : 32'h00000000);
  wire [31:0] memAddr = isLitW ? litW
                      : isLitL ? litL
                      : isAndM ? vn
                      : lsAddr;
  wire [1:0] memSize = isLitW ? `RC_SZ_W
                     : isLitL ? `RC_SZ_L
                     : isAndM ? `RC_SZ_B
                     : ir[3:2];
  wire memWe = isLdSt && ir[0];

  wire [31:0] ldExt =
      (dSize_r == `RC_SZ_B) ? {{24{dRdata[7]}}, dRdata[7:0]}
    : (dSize_r == `RC_SZ_W) ? {{16{dRdata[15]}}, dRdata[15:0]}
    : dRdata;
  wire [31:0] rmwData = {24'h000000, dRdata[7:0] & rmwImm_r};

  wire memAck = (st_r == ST_MEM) && dAck;
  wire rmwRead = rmw_r && !dWe_r;
  wire memWr = memAck && !dWe_r && !rmw_r;
  wire memDone = memAck && !rmwRead;

  wire mulStart = run && isMul;
  wire mulDone = (st_r == ST_MUL) && stateEn_r && (mulCnt_r == 2'h1);
  wire [1:0] mulLat =
      (fn == `RC_FN_MULW) ? `RC_LAT_MULW
    : (fn == `RC_FN_MACW) ? `RC_LAT_MACW
    : (fn == `RC_FN_MULL) ? `RC_LAT_MULL
    : `RC_LAT_MACL;

  wire signed [31:0] p16 = $signed(mulA_r[15:0]) * $signed(mulB_r[15:0]);
  wire signed [63:0] p32 = $signed(mulA_r) * $signed(mulB_r);
  wire [63:0] acc = {mach_r, macl_r};
  wire [63:0] mulRes =
      (mulFn_r == `RC_FN_MULW) ? {mach_r, p16}
    : (mulFn_r == `RC_FN_MACW) ? acc + {{32{p16[31]}}, p16}
    : (mulFn_r == `RC_FN_MULL) ? p32
    : acc + p32;

  wire wbEn = runWr || memWr;
  wire [3:0] wbIdx = memWr ? ldIdx_r : rn;
  wire [31:0] wbData = memWr ? ldExt : runData;

  // Instruction completes and the fetch moves on
  wire adv = (run && !memStart && !mulStart) || memDone || mulDone;

  assign fetchAddr = pc_r;
  assign dReq = dReq_r;
  assign dWe = dWe_r;
  assign dAddr = dAddr_r;
  assign dWdata = dWdata_r;
  assign dSize = dSize_r;
  assign cpuFlagsWord = flags_r;
  assign slotActive = slotPend_r;
  assign retire = retire_r;

  // Core clock divided down to the execution state rate
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      divCnt_r <= 4'h0;
      stateEn_r <= 1'b0;
    end else begin
      divCnt_r <= (divCnt_r == STATE_LAST) ? 4'h0 : divCnt_r + 4'h1;
      stateEn_r <= (divCnt_r == STATE_LAST);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) begin
        regs_r[i] <= 32'h00000000;
      end
    end else if (wbEn) begin
      regs_r[wbIdx] <= wbData;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pc_r <= `RC_RESET_PC;
      slotPend_r <= 1'b0;
      tgt_r <= 32'h00000000;
      retire_r <= 1'b0;
    end else begin
      retire_r <= adv;
      if (adv) begin
        pc_r <= runPc;
        slotPend_r <= run && isDel;
      end
      // Latched now, so a slot write to Rm cannot move it
      if (run && isDel) begin
        tgt_r <= isJmp ? vm : braTgt;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flags_r <= `RC_FLAGS_RST;
    end else if (run && isCmp) begin
      flags_r[`RC_T_BIT] <= cmpVal;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r <= ST_RUN;
    end else begin
      case (st_r)
        ST_RUN: begin
          if (memStart) begin
            st_r <= ST_MEM;
          end else if (mulStart) begin
            st_r <= ST_MUL;
          end
        end
        ST_MEM: begin
          if (memDone) begin
            st_r <= ST_RUN;
          end
        end
        ST_MUL: begin
          if (mulDone) begin
            st_r <= ST_RUN;
          end
        end
        default: st_r <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mulCnt_r <= 2'h0;
      mulA_r <= 32'h00000000;
      mulB_r <= 32'h00000000;
      mulFn_r <= 4'h0;
      mach_r <= 32'h00000000;
      macl_r <= 32'h00000000;
    end else if (mulStart) begin
      mulCnt_r <= mulLat - 2'h1;
      mulA_r <= vn;
      mulB_r <= vm;
      mulFn_r <= fn;
    end else if ((st_r == ST_MUL) && stateEn_r) begin
      mulCnt_r <= mulCnt_r - 2'h1;
      if (mulDone) begin
        mach_r <= mulRes[63:32];
        macl_r <= mulRes[31:0];
      end
    end
  end

  // An acked beat ends a transfer, except the memory AND read beat, which reissues as a write
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dReq_r <= 1'b0;
      dWe_r <= 1'b0;
      dAddr_r <= 32'h00000000;
      dWdata_r <= 32'h00000000;
      dSize_r <= `RC_SZ_B;
      rmw_r <= 1'b0;
      ldIdx_r <= 4'h0;
      rmwImm_r <= 8'h00;
    end else if (memStart) begin
      dReq_r <= 1'b1;
      dWe_r <= memWe;
      dAddr_r <= memAddr;
      dWdata_r <= vm;
      dSize_r <= memSize;
      rmw_r <= isAndM;
      ldIdx_r <= rn;
      rmwImm_r <= imm8;
    end else if (memAck) begin
      if (rmwRead) begin
        dWe_r <= 1'b1;
        dWdata_r <= rmwData;
      end else begin
        dReq_r <= 1'b0;
        rmw_r <= 1'b0;
      end
    end
  end

endmodule

// >>> rc_core_monitor.sv
`timescale 1ns/1ps
`include "rc_params.svh"
module rc_core_monitor (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Fetch and data bus
  input wire logic [31:0] fetchAddr,
  input wire logic [15:0] fetchData,
  input wire logic dReq,
  input wire logic dWe,
  input wire logic [31:0] dAddr,
  input wire rc_pkg::rc_size_t dSize,
  input wire logic dAck,
  // Status
  input wire logic [31:0] cpuFlagsWord,
  input wire logic slotActive
);
  import rc_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire [3:0] op = fetchData[15:12];
  wire [31:0] litW = fetchAddr + 32'h4 + {23'h0, fetchData[7:0], 1'b0};
  wire [31:0] litL = ((fetchAddr + 32'h4) & ~32'h3) +
    {22'h0, fetchData[7:0], 2'h0};
  // Ops below the branch codes, ALU excluded since it holds the jump
  property p_pc_step;
    $changed(fetchAddr) && !$past(slotActive) &&
      $past(op) < `RC_OP_BRA && $past(op) != `RC_OP_ALU
      |-> fetchAddr == $past(fetchAddr) + 32'h2;
  endproperty
  a_pc_step: assert property (p_pc_step)
    else $error("pc did not step by one code word");
  property p_flag_quiet;
    $changed(cpuFlagsWord) |-> $past(op) == `RC_OP_CMPEQI ||
      ($past(op) == `RC_OP_ALU && $past(fetchData[3:1]) == 3'h4);
  endproperty
  a_flag_quiet: assert property (p_flag_quiet)
    else $error("flag changed by a non-compare");
  property p_flag_bits;
    cpuFlagsWord[31:1] == 31'h0;
  endproperty
  a_flag_bits: assert property (p_flag_bits)
    else $error("status word has stray bits");
  property p_slot_end;
    $rose(slotActive) |-> ##[1:40] !slotActive;
  endproperty
  a_slot_end: assert property (p_slot_end)
    else $error("slot never retired");
  property p_hold;
    dReq && !dAck |=> dReq && $stable(dAddr) && $stable(dSize) &&
      $stable(dWe);
  endproperty
  a_hold: assert property (p_hold)
    else $error("data request moved before ack");
  property p_write_drop;
    dReq && dAck && dWe |=> !dReq;
  endproperty
  a_write_drop: assert property (p_write_drop)
    else $error("request held after write ack");
  property p_read_ack;
    dReq && dAck && !dWe |=> !dReq || (dWe && dSize == `RC_SZ_B);
  endproperty
  a_read_ack: assert property (p_read_ack)
    else $error("bad beat after read ack");
  property p_lit_word;
    $rose(dReq) && !slotActive && op == `RC_OP_LITW
      |-> dAddr == litW && dSize == `RC_SZ_W && !dWe;
  endproperty
  a_lit_word: assert property (p_lit_word)
    else $error("word literal address wrong");
  property p_lit_long;
    $rose(dReq) && !slotActive && op == `RC_OP_LITL
      |-> dAddr == litL && dSize == `RC_SZ_L && !dWe;
  endproperty
  a_lit_long: assert property (p_lit_long)
    else $error("longword literal address wrong");
endmodule

bind rc_core rc_core_monitor rc_core_monitor_inst (.ref_clk(ref_clk),
  .rst(rst), .fetchAddr(fetchAddr), .fetchData(fetchData), .dReq(dReq),
  .dWe(dWe), .dAddr(dAddr), .dSize(dSize), .dAck(dAck),
  .cpuFlagsWord(cpuFlagsWord), .slotActive(slotActive));

// >>> rc_params.svh
`ifndef RC_PARAMS_SVH
`define RC_PARAMS_SVH

// Timing
`define RC_CLK_PS 4000
`define RC_STATE_PS 16000
`define RC_STATE_CYC (`RC_STATE_PS / `RC_CLK_PS)

// Major opcodes, code word bits 15:12
`define RC_OP_MOVI 4'h0
`define RC_OP_ADDI 4'h1
`define RC_OP_ANDI 4'h2
`define RC_OP_ALU 4'h3
`define RC_OP_CMPEQI 4'h4
`define RC_OP_LITW 4'h5
`define RC_OP_LITL 4'h6
`define RC_OP_LDST 4'h7
`define RC_OP_ANDM 4'h8
`define RC_OP_BRA 4'h9
`define RC_OP_BT 4'hA
`define RC_OP_BF 4'hB

// Register-register functions, code word bits 3:0
`define RC_FN_ADD 4'h0
`define RC_FN_SUB 4'h1
`define RC_FN_AND 4'h2
`define RC_FN_OR 4'h3
`define RC_FN_XOR 4'h4
`define RC_FN_MOV 4'h5
`define RC_FN_STSL 4'h6
`define RC_FN_STSH 4'h7
`define RC_FN_CMPGE 4'h8
`define RC_FN_CMPEQ 4'h9
`define RC_FN_MULW 4'hA
`define RC_FN_MACW 4'hB
`define RC_FN_MULL 4'hC
`define RC_FN_MACL 4'hD
`define RC_FN_JMP 4'hE

// Access sizes
`define RC_SZ_B 2'h0
`define RC_SZ_W 2'h1
`define RC_SZ_L 2'h2

// Multiply latencies in states
`define RC_LAT_MULW 2'h2
`define RC_LAT_MACW 2'h2
`define RC_LAT_MULL 2'h3
`define RC_LAT_MACL 2'h3

// Reset values and flag positions
`define RC_T_BIT 0
`define RC_RESET_PC 32'h00000000
`define RC_FLAGS_RST 32'h00000000

`endif

// >>> rc_pkg.sv
package rc_pkg;

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_MEM = 3'b010,
    ST_MUL = 3'b100
  } rc_state_t;

  typedef logic [1:0] rc_size_t;

endpackage

// >>> test_risc_core_instruction_semantics.sv
`timescale 1ns/1ps
`include "rc_params.svh"
module test_risc_core_instruction_semantics;
  import rc_pkg::*;
  logic ref_clk = 0;
  logic rst = 1;
  logic dAck = 0;
  logic [31:0] dRdata = 32'h0;
  logic dReq, dWe, slotActive, retire;
  logic [15:0] fetchData;
  logic [31:0] fetchAddr, dAddr, dWdata, cpuFlagsWord;
  rc_size_t dSize;
  logic [15:0] rom [0:63];
  logic [66:0] lg [$];
  logic [31:0] fl [$];
  int rs [$];
  int n_fail = 0, check_count = 0, cyc = 0, lat = 0, wt = 0;
  always #2 ref_clk = ~ref_clk;
  assign fetchData = rom[fetchAddr[6:1]];
  rc_core rc_core_inst (.ref_clk(ref_clk), .rst(rst),
    .fetchAddr(fetchAddr), .fetchData(fetchData), .dReq(dReq), .dWe(dWe),
    .dAddr(dAddr), .dWdata(dWdata), .dSize(dSize), .dRdata(dRdata),
    .dAck(dAck), .cpuFlagsWord(cpuFlagsWord), .slotActive(slotActive),
    .retire(retire));
  // Upper bits set on purpose so a missing extension shows
  function automatic logic [31:0] rdv(logic [31:0] a);
    return 32'h80008080 | a;
  endfunction
  function automatic logic [66:0] bt(logic w, logic [1:0] s,
    logic [31:0] a, logic [31:0] d);
    return {w, s, a, d};
  endfunction
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (retire) rs.push_back(cyc);
  end
  // Memory side: ack after lat idle cycles, bus scrambled when idle
  always @(negedge ref_clk) begin
    if (dReq && !dAck && !rst && wt >= lat) begin
      dAck <= 1;
      wt <= 0;
      dRdata <= rdv(dAddr);
      lg.push_back({dWe, dSize, dAddr, dWe ? dWdata : rdv(dAddr)});
      fl.push_back(cpuFlagsWord);
    end else begin
      dAck <= 0;
      dRdata <= ~dRdata;
      wt <= (dReq && !dAck) ? wt + 1 : 0;
    end
  end
  task automatic chk_beat(logic [66:0] got, logic [66:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_val(logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic run(logic [15:0] p [$], int n);
    int k;
    @(negedge ref_clk);
    rst = 1;
    foreach (rom[i]) rom[i] = (i < p.size()) ? p[i] : 16'hF000;
    repeat (6) @(negedge ref_clk);
    lg.delete();
    fl.delete();
    rs.delete();
    rst = 0;
    for (k = 0; k < 2000 && lg.size() < n; k++) @(negedge ref_clk);
    // A run that never collects its beats counts as a mismatch
    if (lg.size() < n) begin
      n_fail++;
      $display("run stopped short of its beats at t=%0t", $time);
    end
    repeat (40) @(negedge ref_clk);
  endtask
  // Register ALU functions, register compare, untaken branch, indexed store
  task automatic test_alu;
    run('{16'h0440, 16'h0105, 16'h0203, 16'h3315, 16'h3321, 16'h7439,
      16'h3515, 16'h3522, 16'h3615, 16'h3623, 16'h3715, 16'h3724,
      16'h7459, 16'h7469, 16'h7479, 16'h3129, 16'hA001, 16'h7419,
      16'h3119, 16'hA001, 16'h7429, 16'h7429, 16'h0008, 16'h742B,
      16'h7848, 16'h7489}, 8);
    chk_beat(lg[0], bt(1, `RC_SZ_L, 32'h40, 32'h2));
    chk_beat(lg[1], bt(1, `RC_SZ_L, 32'h40, 32'h1));
    chk_beat(lg[2], bt(1, `RC_SZ_L, 32'h40, 32'h7));
    chk_beat(lg[3], bt(1, `RC_SZ_L, 32'h40, 32'h6));
    chk_beat(lg[4], bt(1, `RC_SZ_L, 32'h40, 32'h5));
    chk_val(fl[4], 32'h0);
    chk_beat(lg[5], bt(1, `RC_SZ_L, 32'h48, 32'h3));
    chk_val(fl[5], 32'h1);
    chk_beat(lg[6], bt(0, `RC_SZ_L, 32'h40, rdv(32'h40)));
    chk_beat(lg[7], bt(1, `RC_SZ_L, 32'h40, 32'h800080C0));
    $display("test_alu done");
  endtask
  task automatic test_imm;
    run('{16'h0180, 16'h02FF, 16'h2280, 16'h0300, 16'h13FF, 16'h0440,
      16'h7419, 16'h7429, 16'h7439, 16'h43FF, 16'h1301, 16'h7439}, 4);
    chk_beat(lg[0], bt(1, `RC_SZ_L, 32'h40, 32'hFFFFFF80));
    chk_beat(lg[1], bt(1, `RC_SZ_L, 32'h40, 32'h80));
    chk_beat(lg[2], bt(1, `RC_SZ_L, 32'h40, 32'hFFFFFFFF));
    chk_beat(lg[3], bt(1, `RC_SZ_L, 32'h40, 32'h0));
    chk_val(fl[0], 32'h0);
    chk_val(fl[3], 32'h1);
    $display("test_imm done");
  endtask
  task automatic test_delay;
    run('{16'h050C, 16'h0440, 16'h305E, 16'h0533, 16'h7449, 16'h7449,
      16'h7459, 16'h9002, 16'h1501, 16'h7449, 16'h7449, 16'h7459}, 2);
    chk_beat(lg[0], bt(1, `RC_SZ_L, 32'h40, 32'h33));
    chk_beat(lg[1], bt(1, `RC_SZ_L, 32'h40, 32'h34));
    $display("test_delay done");
  endtask
  task automatic test_cmp;
    run('{16'h0101, 16'h0002, 16'h0440, 16'h3018, 16'h10FF, 16'hA001,
      16'h7449, 16'h7449, 16'h7409, 16'h0180, 16'h3108, 16'hB001,
      16'h7409, 16'h7409, 16'h4001, 16'hB001, 16'h7419}, 2);
    chk_beat(lg[0], bt(1, `RC_SZ_L, 32'h40, 32'h1));
    chk_val(fl[0], 32'h1);
    chk_beat(lg[1], bt(1, `RC_SZ_L, 32'h40, 32'hFFFFFF80));
    chk_val(fl[1], 32'h1);
    $display("test_cmp done");
  endtask
  task automatic test_mem;
    lat = 2;
    run('{16'h0440, 16'h0010, 16'h5100, 16'h6200, 16'h7320, 16'h7516,
      16'h7419, 16'h7429, 16'h7439, 16'h7459}, 8);
    lat = 0;
    chk_beat(lg[0], bt(0, `RC_SZ_W, 32'h8, rdv(32'h8)));
    chk_beat(lg[1], bt(0, `RC_SZ_L, 32'h8, rdv(32'h8)));
    chk_beat(lg[2], bt(0, `RC_SZ_B, 32'h80008088,
      rdv(32'h80008088)));
    chk_beat(lg[3], bt(0, `RC_SZ_W, 32'hFFFF8098,
      rdv(32'hFFFF8098)));
    chk_beat(lg[4], bt(1, `RC_SZ_L, 32'h40, 32'hFFFF8088));
    chk_beat(lg[5], bt(1, `RC_SZ_L, 32'h40, 32'h80008088));
    chk_beat(lg[6], bt(1, `RC_SZ_L, 32'h40, 32'hFFFFFF88));
    chk_beat(lg[7], bt(1, `RC_SZ_L, 32'h40, 32'hFFFF8098));
    $display("test_mem done");
  endtask
  task automatic test_mul;
    run('{16'h01FE, 16'h0203, 16'h312A, 16'h3306, 16'h312B, 16'h312C,
      16'h312D, 16'h3507, 16'h3606, 16'h0440, 16'h7439, 16'h7459,
      16'h7469, 16'h845C}, 5);
    chk_beat(lg[0], bt(1, `RC_SZ_L, 32'h40, 32'hFFFFFFFA));
    chk_beat(lg[1], bt(1, `RC_SZ_L, 32'h40, 32'hFFFFFFFF));
    chk_beat(lg[2], bt(1, `RC_SZ_L, 32'h40, 32'hFFFFFFF4));
    chk_beat(lg[3], bt(0, `RC_SZ_B, 32'h40, rdv(32'h40)));
    chk_beat({lg[4][66:32], 24'h0, lg[4][7:0]},
      bt(1, `RC_SZ_B, 32'h40, 32'h40));
    chk_val(32'(rs[2] - rs[1]), 32'h8);
    chk_val(32'(rs[4] - rs[3]), 32'h8);
    chk_val(32'(rs[5] - rs[4]), 32'hC);
    chk_val(32'(rs[6] - rs[5]), 32'hC);
    chk_val(32'(rs[7] - rs[6]), 32'h4);
    $display("test_mul done");
  endtask
  task automatic report_and_stop;
    $display("checks=%0d fails=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Six runs of about two thousand cycles at most
  initial begin
    #200000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    foreach (rom[i]) rom[i] = 16'hF000;
    test_imm();
    test_delay();
    test_cmp();
    test_mem();
    test_mul();
    test_alu();
    report_and_stop();
  end
endmodule
